// ---- design/uart_status_baud_break.sv ----
// serial unit with fifos, interrupt flags, baud divisor and break/sync
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Overview of operation
// - a read of the empty receive fifo sets the underflow flag; writing one enables its irq, writing zero clears flag and enable, fifo flush clears it.
// - a write to the full transmit fifo sets the overflow flag; same enable, clear and flush behaviour.
// - a received byte with a low stop bit sets the framing flag, cleared only by writing zero which also disables it.
// - the transmit-complete flag sets when the last queued byte has left and the fifo is empty, cleared only by writing zero.
// - reading the data port returns the oldest receive byte and removes it.
// - writing the data port pushes the byte into the transmit fifo.
// - one bit time is the divisor plus one clocks, the divisor split over low and high byte registers.
// - with the break irq enable set, a finished break or break-plus-sync raises the interrupt.
// - a two-bit field picks the receive sampling point at 50, 62.5, 69 or 75 percent of the bit.
// - hardware sets the break-done flag when a break sequence ends and never clears it itself.
// - with send-sync clear only the break goes out, with it set a sync byte follows the break.
// - the break lasts 13, 14, 15 or 16 bit times as the length field selects.
// - data port, both divisor bytes and the break configuration read zero after reset.
// - a master enable bit gates every interrupt request and resets to zero.
// ------------------------------------------------------------------
module uart_status_baud_break
  import uart_status_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] address,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire logic       fifoFlush,
  input  wire logic       rxd,
  output logic            txd,
  output logic            irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][7:0]   txMem;
    logic [FIFO_AW-1:0] txRd;
    logic [FIFO_AW-1:0] txWr;
    logic [4:0]         txCount;
    logic [15:0][7:0]   rxMem;
    logic [FIFO_AW-1:0] rxRd;
    logic [FIFO_AW-1:0] rxWr;
    logic [4:0]         rxCount;
    logic [15:0]        divisor;
    logic               break_done_irq_en;
    logic [1:0]         sampleSel;
    logic               brkFlag;
    logic               sendSync;
    logic [1:0]         break_length_sel;
    logic               brkReq;
    logic [3:0]         flags;
    logic [3:0]         irqEn;
    logic               masterEn;
    logic [7:0]         rdData;
    tx_state_type       txState;
    logic [15:0]        txCnt;
    logic [3:0]         txBit;
    logic [7:0]         txShift;
    logic               txLow;
    logic               syncActive;
    rx_state_type       rxState;
    logic [15:0]        rxCnt;
    logic [3:0]         rxBit;
    logic [7:0]         rxShift;
    logic               rxPrev;
  } state_type;

  state_type s;
  state_type next_s;

  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] want);
    hit = strobe && (a == want);
  endfunction : hit

  function automatic logic [15:0] samplePoint(input logic [15:0] div,
                                              input logic [1:0]  sel);
    logic [16:0] bitLen;
    logic [16:0] p;
    bitLen = {1'b0, div} + 17'h00001;
    unique case (sel)
      2'b00: p = bitLen >> 1;
      2'b01: p = (bitLen >> 1) + (bitLen >> 3);
      2'b10: p = (bitLen >> 1) + (bitLen >> 3) + (bitLen >> 4);
      2'b11: p = (bitLen >> 1) + (bitLen >> 2);
    endcase
    samplePoint = p[15:0] - 16'h0001;
  endfunction : samplePoint

  logic wrIrq, wrData_, rdData_, wrBrk, txBitEnd, rxBitEnd, txPop, rxPush;
  logic [7:0] txBitsLast;

  assign wrIrq    = hit(wrStrobe, address, ADDR_IRQ);
  assign wrData_  = hit(wrStrobe, address, ADDR_DATA);
  assign rdData_  = hit(rdStrobe, address, ADDR_DATA);
  assign wrBrk    = hit(wrStrobe, address, ADDR_BRK);
  assign txBitEnd = s.txCnt == s.divisor;
  assign rxBitEnd = s.rxCnt == s.divisor;
  assign txBitsLast = {6'h00, s.break_length_sel} + {4'h0, BREAK_LAST_MIN};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    txPop  = 1'b0;
    rxPush = 1'b0;
    next_s.rxPrev = rxd;
    // register writes
    if (wrIrq) begin
      next_s.masterEn = wrData[IRQ_MASTER];
      next_s.irqEn    = wrData[3:0];
      next_s.flags    = s.flags & wrData[3:0];
    end
    if (hit(wrStrobe, address, ADDR_BAUDL)) begin
      next_s.divisor[7:0] = wrData;
    end
    if (hit(wrStrobe, address, ADDR_BAUDH)) begin
      next_s.divisor[15:8] = wrData;
    end
    if (wrBrk) begin
      next_s.break_done_irq_en    = wrData[BRK_IEN];
      next_s.sampleSel = wrData[BRK_SPL_LSB +: 2];
      next_s.brkFlag   = s.brkFlag & wrData[BRK_FLAG];
      next_s.sendSync  = wrData[BRK_SYNC];
      next_s.break_length_sel    = wrData[BRK_LEN_LSB +: 2];
    end
    if (hit(wrStrobe, address, ADDR_START) && wrData[START_BIT]) begin
      next_s.brkReq = 1'b1;
    end
    // register reads
    next_s.rdData = RESET_BYTE;
    if (rdStrobe) begin
      unique case (address)
        ADDR_IRQ:   next_s.rdData = {s.masterEn, 3'b000, s.flags};
        ADDR_DATA:  next_s.rdData = (s.rxCount != 5'h00) ? s.rxMem[s.rxRd] : RESET_BYTE;
        ADDR_BAUDL: next_s.rdData = s.divisor[7:0];
        ADDR_BAUDH: next_s.rdData = s.divisor[15:8];
        ADDR_START: next_s.rdData = {7'h00, s.brkReq || (s.txState == TX_BREAK)};
        ADDR_BRK:   next_s.rdData = {s.break_done_irq_en, 1'b0, s.sampleSel, s.brkFlag,
                                     s.sendSync, s.break_length_sel};
        default:    next_s.rdData = RESET_BYTE;
      endcase
    end
    // transmitter
    next_s.txCnt = txBitEnd ? 16'h0000 : s.txCnt + 16'h0001;
    unique case (s.txState)
      TX_IDLE: begin
        next_s.txCnt = 16'h0000;
        if (s.brkReq) begin
          next_s.brkReq  = 1'b0;
          next_s.txBit   = 4'h0;
          next_s.txState = TX_BREAK;
        end else if (s.txCount != 5'h00) begin
          txPop          = 1'b1;
          next_s.txShift = s.txMem[s.txRd];
          next_s.txState = TX_START;
        end
      end
      TX_START: begin
        if (txBitEnd) begin
          next_s.txBit   = 4'h0;
          next_s.txState = TX_DATA;
        end
      end
      TX_DATA: begin
        if (txBitEnd) begin
          next_s.txShift = {1'b1, s.txShift[7:1]};
          next_s.txBit   = s.txBit + 4'h1;
          if (s.txBit == LAST_DATA_BIT) begin
            next_s.txState = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (txBitEnd) begin
          next_s.txState = TX_IDLE;
          if (s.syncActive) begin
            next_s.syncActive = 1'b0;
            next_s.brkFlag    = 1'b1;
          end else if (s.txCount == 5'h00) begin
            next_s.flags[FLAG_TX_DONE] = 1'b1;
          end
        end
      end
      TX_BREAK: begin
        if (txBitEnd) begin
          next_s.txBit = s.txBit + 4'h1;
          if ({4'h0, s.txBit} == txBitsLast) begin
            next_s.txState = TX_DELIM;
          end
        end
      end
      TX_DELIM: begin
        if (txBitEnd) begin
          if (s.sendSync) begin
            next_s.txShift    = SYNC_BYTE;
            next_s.syncActive = 1'b1;
            next_s.txState    = TX_START;
          end else begin
            next_s.brkFlag = 1'b1;
            next_s.txState = TX_IDLE;
          end
        end
      end
      default: next_s.txState = TX_IDLE;
    endcase
    next_s.txLow = (next_s.txState == TX_START) || (next_s.txState == TX_BREAK) ||
                   ((next_s.txState == TX_DATA) && !next_s.txShift[0]);
    // receiver
    next_s.rxCnt = rxBitEnd ? 16'h0000 : s.rxCnt + 16'h0001;
    unique case (s.rxState)
      RX_IDLE: begin
        next_s.rxCnt = 16'h0000;
        if (s.rxPrev && !rxd) begin
          next_s.rxBit   = 4'h0;
          next_s.rxState = RX_BUSY;
        end
      end
      RX_BUSY: begin
        if (rxBitEnd) begin
          next_s.rxBit = s.rxBit + 4'h1;
        end
        if (s.rxCnt == samplePoint(s.divisor, s.sampleSel)) begin
          if (s.rxBit == 4'h0) begin
            if (rxd) begin
              next_s.rxState = RX_IDLE;
            end
          end else if (s.rxBit == RX_STOP_INDEX) begin
            rxPush         = 1'b1;
            next_s.rxState = RX_IDLE;
            if (!rxd) begin
              next_s.flags[FLAG_FRAMING] = 1'b1;
            end
          end else begin
            next_s.rxShift = {rxd, s.rxShift[7:1]};
          end
        end
      end
    endcase
    // transmit fifo
    if (wrData_) begin
      if (s.txCount == FIFO_DEPTH && !txPop) begin
        next_s.flags[FLAG_OVERFLOW] = 1'b1;
      end else begin
        next_s.txMem[s.txWr] = wrData;
        next_s.txWr          = s.txWr + 4'h1;
      end
    end
    if (txPop) begin
      next_s.txRd = s.txRd + 4'h1;
    end
    next_s.txCount = s.txCount + {4'h0, wrData_ && !(s.txCount == FIFO_DEPTH && !txPop)}
                     - {4'h0, txPop};
    // receive fifo
    if (rdData_ && s.rxCount == 5'h00) begin
      next_s.flags[FLAG_UNDERFLOW] = 1'b1;
    end
    if (rxPush && (s.rxCount != FIFO_DEPTH)) begin
      next_s.rxMem[s.rxWr] = s.rxShift;
      next_s.rxWr          = s.rxWr + 4'h1;
    end
    if (rdData_ && s.rxCount != 5'h00) begin
      next_s.rxRd = s.rxRd + 4'h1;
    end
    next_s.rxCount = s.rxCount + {4'h0, rxPush && (s.rxCount != FIFO_DEPTH)}
                     - {4'h0, rdData_ && (s.rxCount != 5'h00)};
    // fifo flush
    if (fifoFlush) begin
      next_s.txRd    = 4'h0;
      next_s.txWr    = 4'h0;
      next_s.txCount = 5'h00;
      next_s.rxRd    = 4'h0;
      next_s.rxWr    = 4'h0;
      next_s.rxCount = 5'h00;
      next_s.flags[FLAG_UNDERFLOW] = rdData_ && (s.rxCount == 5'h00);
      next_s.flags[FLAG_OVERFLOW]  = wrData_ && (s.txCount == FIFO_DEPTH) && !txPop;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData = s.rdData;
  assign txd    = ~s.txLow;
  assign irq    = s.masterEn && (|(s.flags & s.irqEn) || (s.brkFlag && s.break_done_irq_en));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_irq_master_gate: assert property (irq |-> s.masterEn)
    else $error("interrupt raised with master enable clear");
  a_irq_on_flag: assert property (s.masterEn && s.flags[FLAG_TX_DONE] && s.irqEn[FLAG_TX_DONE]
                                  |-> irq)
    else $error("enabled flag did not raise interrupt");
  a_brk_irq_path: assert property (s.masterEn && s.break_done_irq_en && s.brkFlag |-> irq)
    else $error("break completion did not raise interrupt");
  a_underflow_set: assert property (rdData_ && s.rxCount == 5'h00 && !fifoFlush
                                    |=> s.flags[FLAG_UNDERFLOW])
    else $error("underflow flag not set");
  a_overflow_set: assert property (wrData_ && s.txCount == FIFO_DEPTH && !txPop && !fifoFlush
                                   |=> s.flags[FLAG_OVERFLOW])
    else $error("overflow flag not set");
  a_frame_sticky: assert property (s.flags[FLAG_FRAMING] && !wrIrq |=> s.flags[FLAG_FRAMING])
    else $error("framing flag cleared without a write");
  a_tx_done_set: assert property (s.txState == TX_STOP && txBitEnd && !s.syncActive
                                  && s.txCount == 5'h00 |=> s.flags[FLAG_TX_DONE])
    else $error("transmit complete flag not set");
  a_rx_pop: assert property (rdData_ && s.rxCount != 5'h00 && !rxPush && !fifoFlush
                             |=> rdData == $past(s.rxMem[s.rxRd])
                                 && s.rxCount == $past(s.rxCount) - 5'h01)
    else $error("data port read did not pop oldest byte");
  a_tx_push: assert property (wrData_ && s.txCount < FIFO_DEPTH && !fifoFlush
                              |=> s.txMem[$past(s.txWr)] == $past(wrData))
    else $error("data port write not queued");
  a_bit_period: assert property (s.txState == TX_START && s.txCnt == 16'h0000
                                 && s.divisor == 16'h0009 && !wrStrobe
                                 |-> ##10 s.txState == TX_DATA)
    else $error("bit time differs from divisor plus one");
  a_brk_flag_hold: assert property (s.brkFlag && !wrBrk |=> s.brkFlag)
    else $error("break flag cleared by hardware");
  a_sync_follows: assert property (s.txState == TX_DELIM && txBitEnd && s.sendSync
                                   |=> s.txState == TX_START && s.txShift == SYNC_BYTE)
    else $error("sync byte did not follow break");
  a_break_low: assert property (s.txState == TX_BREAK |=> !txd || s.txState == TX_DELIM)
    else $error("line not low during break");
  a_reset_zero: assert property (disable iff (1'b0) reset |=> s.divisor == 16'h0000
                                 && {s.break_done_irq_en, s.sampleSel, s.brkFlag, s.sendSync,
                                     s.break_length_sel} == 7'h00 && !s.masterEn)
    else $error("registers not zero after reset");

  c_break_done: cover property (s.txState == TX_DELIM ##1 s.brkFlag);
  c_sync_sent: cover property (s.syncActive && s.txState == TX_STOP ##1 s.brkFlag);
  c_tx_complete: cover property ($rose(s.flags[FLAG_TX_DONE]));
  c_rx_framing: cover property ($rose(s.flags[FLAG_FRAMING]));
endmodule : uart_status_baud_break
`default_nettype wire

// ---- design/uart_status_pkg.sv ----
// constants and types of the serial unit status, baud and break block
package uart_status_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ   = 8'hB4;
  localparam logic [7:0] ADDR_DATA  = 8'hB5;
  localparam logic [7:0] ADDR_BAUDL = 8'hB6;
  localparam logic [7:0] ADDR_BAUDH = 8'hB7;
  localparam logic [7:0] ADDR_START = 8'hC0;
  localparam logic [7:0] ADDR_BRK   = 8'hC1;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IRQ_MASTER     = 7;
  localparam int FLAG_UNDERFLOW = 3;
  localparam int FLAG_OVERFLOW  = 2;
  localparam int FLAG_FRAMING   = 1;
  localparam int FLAG_TX_DONE   = 0;
  localparam int BRK_IEN        = 7;
  localparam int BRK_SPL_LSB    = 4;
  localparam int BRK_FLAG       = 3;
  localparam int BRK_SYNC       = 2;
  localparam int BRK_LEN_LSB    = 0;
  localparam int START_BIT      = 0;
  // ----------------------------------------------------------------
  // reset values, sizes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam int          FIFO_AW        = 4;
  localparam logic [4:0]  FIFO_DEPTH     = 5'h10;
  localparam logic [3:0]  LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0]  RX_STOP_INDEX  = 4'h9;
  localparam logic [3:0]  BREAK_LAST_MIN = 4'hC;
  localparam logic [7:0]  SYNC_BYTE      = 8'h55;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_STOP  = 3'b010,
    TX_BREAK = 3'b110,
    TX_DELIM = 3'b111
  } tx_state_type;
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BUSY = 1'b1
  } rx_state_type;
endpackage : uart_status_pkg

// ---- verif/serial_peer.sv ----
// serial peer model: sends frames on rxd, decodes frames and breaks seen on txd
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic        clk_sys,
  input  wire logic        txd,
  input  wire logic [16:0] bitTicks,
  output var  logic        rxd
);
  logic [7:0] gotQ[$];
  int         brkQ[$];
  int         events = 0;
  initial rxd = 1'b1;
  // ----------------------------------------------------------------
  // send one frame, stop level selectable, then one idle bit
  // ----------------------------------------------------------------
  task automatic sendByte(input logic [7:0] b, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, b, 1'b0};
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bitTicks) @(posedge clk_sys);
    end
    rxd <= 1'b1;
    repeat (bitTicks) @(posedge clk_sys);
  endtask : sendByte
  // ----------------------------------------------------------------
  // decode frames; a low stop bit means a break, measured in clocks
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin : decode
    int         e;
    logic [8:0] sh;
    if (txd === 1'b0) begin
      repeat (bitTicks / 2) @(posedge clk_sys);
      e = bitTicks / 2;
      for (int i = 0; i < 9; i++) begin
        repeat (bitTicks) @(posedge clk_sys);
        sh[i] = txd;
      end
      e += 9 * bitTicks;
      if (sh[8] === 1'b1) begin
        gotQ.push_back(sh[7:0]);
      end else begin
        while (txd === 1'b0) begin
          @(posedge clk_sys);
          e++;
        end
        brkQ.push_back(e);
      end
      events++;
    end
  end
endmodule : serial_peer
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the serial unit status, baud and break block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import uart_status_pkg::*;
;
  logic        clk_sys, reset, wrStrobe, rdStrobe, fifoFlush, rxd, txd, irq;
  logic [7:0]  address, wrData, rdData;
  logic [16:0] bitTicks;
  int          errCount = 0;
  int          nCompared = 0;
  logic [7:0]  rxModel[$];
  logic [7:0]  txModel[$];
  logic [7:0]  regs[4] = '{ADDR_DATA, ADDR_BAUDL, ADDR_BAUDH, ADDR_BRK};

  uart_status_baud_break dut (.clk_sys(clk_sys), .reset(reset), .address(address),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .fifoFlush(fifoFlush), .rxd(rxd), .txd(txd), .irq(irq));
  serial_peer peer (.clk_sys(clk_sys), .txd(txd), .bitTicks(bitTicks), .rxd(rxd));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // bus, compare and wait tasks
  // ----------------------------------------------------------------
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : printVerdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    nCompared++;
    if (seen !== want) begin
      errCount++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address  <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    address  <= a;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] w, input logic [7:0] m);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, w & m);
  endtask : rdc
  task automatic pollBit(input logic [7:0] a, input logic [7:0] m, input logic [7:0] w);
    logic [7:0] d;
    for (int i = 0; i < 400; i++) begin
      rd(a, d);
      if ((d & m) === w) break;
    end
    chk(d & m, w);
    if ((d & m) !== w) printVerdict();
  endtask : pollBit
  task automatic waitEvents(input int n);
    for (int i = 0; i < 20000 && peer.events < n; i++) @(posedge clk_sys);
    if (peer.events < n) begin
      errCount++;
      $display("BAD %0t serial line timeout", $time);
      printVerdict();
    end
  endtask : waitEvents
  task automatic flush();
    @(posedge clk_sys);
    fifoFlush <= 1'b1;
    @(posedge clk_sys);
    fifoFlush <= 1'b0;
    #1;
  endtask : flush
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    int         div;
    int         evt;
    logic [7:0] b;
    logic [7:0] cfg;
    reset = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    fifoFlush = 1'b0;
    address = 8'h00;
    wrData = 8'h00;
    bitTicks = 17'h00004;
    evt = 0;
    void'($urandom(32'hC26503ED));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (regs[i]) rdc(regs[i], RESET_BYTE, 8'hFF);
    rdc(ADDR_IRQ, 8'h00, 8'h80);
    chk({7'h00, irq}, 8'h00);
    $display("test reset done");
    div = 3 + $urandom_range(0, 3);
    bitTicks <= 17'(div + 1);
    wr(ADDR_BAUDH, 8'hA5);
    rdc(ADDR_BAUDH, 8'hA5, 8'hFF);
    wr(ADDR_BAUDH, 8'h00);
    wr(ADDR_BAUDL, 8'(div));
    rdc(ADDR_BAUDL, 8'(div), 8'hFF);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      txModel.push_back(b);
      wr(ADDR_DATA, b);
    end
    evt += 2;
    waitEvents(evt);
    while (txModel.size() > 0) chk(peer.gotQ.pop_front(), txModel.pop_front());
    pollBit(ADDR_IRQ, 8'h01, 8'h01);
    wr(ADDR_IRQ, 8'h81);
    chk({7'h00, irq}, 8'h01);
    rdc(ADDR_IRQ, 8'h81, 8'h8F);
    wr(ADDR_IRQ, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_IRQ, 8'h80);
    rdc(ADDR_IRQ, 8'h80, 8'h8F);
    $display("test transmit done");
    for (int sp = 0; sp < 4; sp++) begin
      wr(ADDR_BRK, 8'(sp << BRK_SPL_LSB));
      b = 8'($urandom);
      rxModel.push_back(b);
      peer.sendByte(b, 1'b1);
    end
    while (rxModel.size() > 0) rdc(ADDR_DATA, rxModel.pop_front(), 8'hFF);
    rd(ADDR_DATA, b);
    rdc(ADDR_IRQ, 8'h88, 8'h8F);
    wr(ADDR_IRQ, 8'h88);
    chk({7'h00, irq}, 8'h01);
    flush();
    rdc(ADDR_IRQ, 8'h80, 8'h8F);
    $display("test receive done");
    bitTicks <= 17'h0000A;
    wr(ADDR_BAUDL, 8'h09);
    for (int i = 0; i < 18; i++) begin
      b = 8'($urandom);
      if (i == 0) txModel.push_back(b);
      wr(ADDR_DATA, b);
    end
    wr(ADDR_IRQ, 8'h84);
    chk({7'h00, irq}, 8'h01);
    flush();
    rdc(ADDR_IRQ, 8'h80, 8'h84);
    evt += 1;
    waitEvents(evt);
    chk(peer.gotQ.pop_front(), txModel.pop_front());
    pollBit(ADDR_IRQ, 8'h01, 8'h01);
    wr(ADDR_IRQ, 8'h80);
    $display("test overflow done");
    b = 8'($urandom);
    peer.sendByte(b, 1'b0);
    rdc(ADDR_IRQ, 8'h02, 8'h02);
    rdc(ADDR_DATA, b, 8'hFF);
    rdc(ADDR_IRQ, 8'h02, 8'h02);
    wr(ADDR_IRQ, 8'h82);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_IRQ, 8'h80);
    rdc(ADDR_IRQ, 8'h80, 8'h8F);
    $display("test framing done");
    for (int m = 0; m < 8; m++) begin
      cfg = {1'b1, 3'b000, 1'b0, m[2], m[1:0]};
      wr(ADDR_BRK, cfg);
      chk({7'h00, irq}, 8'h00);
      wr(ADDR_START, 8'h01);
      rdc(ADDR_START, 8'h01, 8'hFF);
      evt += m[2] ? 2 : 1;
      waitEvents(evt);
      pollBit(ADDR_BRK, 8'h08, 8'h08);
      rdc(ADDR_BRK, cfg | 8'h08, 8'hFF);
      chk({7'h00, irq}, 8'h01);
      chk(8'(peer.brkQ.pop_front()), 8'((13 + m[1:0]) * bitTicks));
      if (m[2]) chk(peer.gotQ.pop_front(), SYNC_BYTE);
      else chk(8'(peer.gotQ.size()), 8'h00);
      wr(ADDR_BRK, cfg);
      chk({7'h00, irq}, 8'h00);
    end
    $display("test break done");
    printVerdict();
  end
endmodule : tb_top
`default_nettype wire
